// ===== hdl/mpp_port.sv
// Purpose: Multiplexed 16-line address/data port with flag and signal pin muxing
// Assumes: Pins synchronous to i_clock; testbench resolves tri-state wires
// Notes:   Latch strobe idles at its inactive level, set by i_ale_active_low, except in reset, which drives it low
`timescale 1ns/1ps
module mpp_port
    import mpp_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic [CTL_W-1:0]  i_sys_control,
    input  wire logic              i_port_en,
    input  wire logic              i_ale_active_low,
    input  wire logic              i_spi_boot,
    input  wire logic              i_req_valid,
    input  wire mpp_req_t          i_req,
    output logic                   o_req_ready,
    output logic                   o_rd_valid,
    output logic [DATA_W-1:0]      o_rd_data,
    input  wire logic [DATA_W-1:0] i_ad,
    output logic [DATA_W-1:0]      o_ad,
    output logic [DATA_W-1:0]      o_ad_oe,
    output logic [DATA_W-1:0]      o_ad_pullup_en,
    output logic                   o_rd_n,
    output logic                   o_wr_n,
    output logic                   o_ale,
    input  wire logic [DATA_W-1:0] i_pflag_out,
    input  wire logic [DATA_W-1:0] i_pflag_oe,
    output logic [DATA_W-1:0]      o_pflag_in,
    output logic [DATA_W-1:0]      o_in_port_ch0_data,
    input  wire mpp_gsp_cfg_t      i_gsp_cfg,
    input  wire logic              i_timer_expired,
    input  wire logic [NGSP-1:0]   i_gsp,
    output logic [NGSP-1:0]        o_gsp,
    output logic [NGSP-1:0]        o_gsp_oe,
    output logic [NGSP-1:0]        o_gsp_cond,
    output logic [2:0]             o_irq
);

    // ==========================================================
    // Mode decode
    // ==========================================================
    logic       flag_mode;
    mpp_state_t state;
    mpp_req_t   cur;
    logic [ADDR_W-1:0] last_addr;
    logic       addr_known;
    logic [1:0] cnt;
    logic       addr_change;

    assign flag_mode   = i_sys_control[CTL_PFLAG_BIT] && !i_port_en;
    assign o_req_ready = (state == ST_IDLE) && i_port_en && !flag_mode;

    // Address phase needed when the latched part changes
    always_comb
    begin
        if (cur.wide)
            addr_change = !addr_known || (cur.addr[15:0] != last_addr[15:0]);
        else
            addr_change = !addr_known || (cur.addr[23:8] != last_addr[23:8]);
    end

    // ==========================================================
    // Access sequencer
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state      <= ST_IDLE;
            cur        <= '0;
            last_addr  <= '0;
            addr_known <= 1'b0;
            cnt        <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (i_req_valid && o_req_ready)
                    begin
                        cur   <= i_req;
                        state <= ST_ALE;
                    end
                end
                ST_ALE:
                begin
                    if (addr_change)
                    begin
                        last_addr  <= cur.addr;
                        addr_known <= 1'b1;
                        state      <= ST_HOLD;
                    end
                    else
                    begin
                        cnt   <= 2'(STROBE_CYC);
                        state <= ST_STROBE;
                    end
                end
                ST_HOLD:
                begin
                    cnt    <= 2'(STROBE_CYC);
                    state  <= ST_STROBE;
                end
                ST_STROBE:
                begin
                    if (cnt == CNT_ONE)
                        state <= ST_DONE;
                    cnt <= cnt - CNT_ONE;
                end
                ST_DONE:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Pin drive: strobes and shared lines
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_rd_n         <= 1'b1;
            o_wr_n         <= 1'b1;
            o_ale          <= 1'b0;
            o_ad           <= '0;
            o_ad_oe        <= '0;
            o_ad_pullup_en <= '1;
        end
        else
        begin
            o_ad_pullup_en <= '1;
            if (flag_mode)
            begin
                o_rd_n  <= 1'b1;
                o_wr_n  <= 1'b1;
                o_ale   <= i_ale_active_low;
                o_ad    <= i_pflag_out;
                o_ad_oe <= i_pflag_oe;
            end
            else
            begin
                o_ale  <= (state == ST_ALE && addr_change) ^ i_ale_active_low;
                o_rd_n <= !(state == ST_STROBE && !cur.wr);
                o_wr_n <= !(state == ST_STROBE && cur.wr);
                if (state == ST_ALE && addr_change)
                begin
                    o_ad    <= cur.wide ? cur.addr[15:0] : cur.addr[23:8];
                    o_ad_oe <= '1;
                end
                else if (state == ST_HOLD || (state == ST_STROBE && cur.wr))
                begin
                    o_ad    <= cur.wide ? cur.data : {8'h00, cur.data[7:0]};
                    o_ad_oe <= cur.wide ? 16'hffff : 16'h00ff;
                end
                else
                    o_ad_oe <= '0;
            end
        end
    end

    // Read capture at strobe end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end
        else
        begin
            o_rd_valid <= (state == ST_STROBE) && (cnt == CNT_ONE) && !cur.wr;
            if ((state == ST_STROBE) && (cnt == CNT_ONE) && !cur.wr)
                o_rd_data <= cur.wide ? i_ad : {8'h00, i_ad[7:0]};
        end
    end

    // Flag inputs and input data port channel zero
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_pflag_in         <= '0;
            o_in_port_ch0_data <= '0;
        end
        else
        begin
            o_pflag_in <= flag_mode ? i_ad : '0;
            if (flag_mode)
                o_in_port_ch0_data <= i_ad;
        end
    end

    // ==========================================================
    // General signal pins
    // ==========================================================
    logic [NGSP-1:0] alt_in;
    logic [NGSP-1:0] next_gsp;
    logic [NGSP-1:0] next_oe;

    assign alt_in = {1'b0, i_sys_control[CTL_EXT_INT2_BIT], i_sys_control[CTL_EXT_INT1_BIT],
                     i_sys_control[CTL_EXT_INT0_BIT]};

    generate
        for (genvar g = 0; g < NGSP; g++)
        begin : g_gsp
            always_comb
            begin
                if (g == 0 && i_spi_boot)
                begin
                    next_oe[g]  = 1'b1;
                    next_gsp[g] = i_gsp_cfg.spi_sel[g];
                end
                else if (alt_in[g])
                begin
                    next_oe[g]  = 1'b0;
                    next_gsp[g] = 1'b0;
                end
                else if (g == 3 && i_sys_control[CTL_TMR_EXP_BIT])
                begin
                    next_oe[g]  = 1'b1;
                    next_gsp[g] = i_timer_expired;
                end
                else if (i_gsp_cfg.spi_sel_en[g])
                begin
                    next_oe[g]  = 1'b1;
                    next_gsp[g] = i_gsp_cfg.spi_sel[g];
                end
                else
                begin
                    next_oe[g]  = i_gsp_cfg.dir_out[g];
                    next_gsp[g] = i_gsp_cfg.out_val[g];
                end
            end
        end
    endgenerate

    // Registered pin drive, condition and interrupt inputs
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_gsp      <= '0;
            o_gsp_oe   <= '0;
            o_gsp_cond <= '0;
            o_irq      <= '0;
        end
        else
        begin
            o_gsp      <= next_gsp;
            o_gsp_oe   <= next_oe;
            o_gsp_cond <= i_gsp;
            o_irq      <= i_gsp[2:0] & alt_in[2:0];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_flag_strobes_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(flag_mode) && !$past(i_rst) |-> o_rd_n && o_wr_n && (o_ale == $past(i_ale_active_low)))
        else $error("strobe active in flag mode");
    a_rd_strobe_low: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == ST_STROBE && !cur.wr && !flag_mode) |=> !o_rd_n)
        else $error("read strobe not low");
    a_wr_strobe_low: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == ST_STROBE && cur.wr && !flag_mode) |=> !o_wr_n)
        else $error("write strobe not low");
    a_no_rd_wr_both: assert property (@(posedge i_clock) disable iff (i_rst)
        !(!o_rd_n && !o_wr_n))
        else $error("read and write both low");
    a_ale_addr_phase: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == ST_ALE && addr_change && !flag_mode) |=> (o_ale != i_ale_active_low) && (o_ad_oe == 16'hffff))
        else $error("address phase without strobe");
    a_ale_one_cycle: assert property (@(posedge i_clock) disable iff (i_rst)
        (state == ST_HOLD && !flag_mode) |=> (o_ale == $past(i_ale_active_low)))
        else $error("latch strobe too long");
    a_tmr_exp_out: assert property (@(posedge i_clock) disable iff (i_rst)
        i_sys_control[CTL_TMR_EXP_BIT] && !i_spi_boot |=> o_gsp_oe[3] && (o_gsp[3] == $past(i_timer_expired)))
        else $error("timer expiry pin wrong");
    a_irq_pin_input: assert property (@(posedge i_clock) disable iff (i_rst)
        i_sys_control[CTL_EXT_INT1_BIT] |=> !o_gsp_oe[1] && (o_irq[1] == $past(i_gsp[1])))
        else $error("interrupt pin driven");
    a_boot_select: assert property (@(posedge i_clock) disable iff (i_rst)
        i_spi_boot |=> o_gsp_oe[0])
        else $error("boot select not driven");
    a_reset_pins: assert property (@(posedge i_clock)
        $past(i_rst) |-> (o_ad_oe == '0) && o_rd_n && o_wr_n && !o_ale && (o_ad_pullup_en == '1))
        else $error("reset pin state wrong");
    a_in_port_capture: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_mode |=> (o_in_port_ch0_data == $past(i_ad)))
        else $error("input port channel not fed");

    c_read_access:  cover property (@(posedge i_clock) disable iff (i_rst) !o_rd_n ##[1:4] o_rd_valid);
    c_write_access: cover property (@(posedge i_clock) disable iff (i_rst) !o_wr_n);
    c_flag_mode:    cover property (@(posedge i_clock) disable iff (i_rst) flag_mode ##1 o_ad_oe != '0);
    c_skip_ale:     cover property (@(posedge i_clock) disable iff (i_rst) state == ST_ALE && !addr_change);
    c_narrow_ale:   cover property (@(posedge i_clock) disable iff (i_rst) state == ST_ALE && addr_change && !cur.wide);

endmodule : mpp_port

// ===== hdl/mpp_pkg.sv
// Purpose: Constants and types for the muxed parallel port and flag pins
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes:   Control bits are plain ports; no register bus
package mpp_pkg;
    localparam int CTL_EXT_INT0_BIT = 16;
    localparam int CTL_EXT_INT1_BIT = 17;
    localparam int CTL_EXT_INT2_BIT = 18;
    localparam int CTL_TMR_EXP_BIT  = 19;
    localparam int CTL_PFLAG_BIT = 20;
    localparam int CTL_W         = 32;
    localparam int ADDR_W        = 24;
    localparam int DATA_W        = 16;
    localparam int NGSP          = 4;
    localparam int STROBE_NS     = 10;
    localparam int CLK_NS        = 5;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] CNT_ONE = 2'h1;

    typedef struct packed {
        logic              wr;
        logic              wide;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mpp_req_t;

    typedef struct packed {
        logic [NGSP-1:0] dir_out;
        logic [NGSP-1:0] out_val;
        logic [NGSP-1:0] spi_sel_en;
        logic [NGSP-1:0] spi_sel;
    } mpp_gsp_cfg_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_HOLD, ST_STROBE, ST_DONE} mpp_state_t;
endpackage : mpp_pkg

// ===== sim/mpp_mem_model.sv
// Purpose: External address latch and memory on the shared port lines
// Assumes: Bench resolves the lines; released lines read as pull-up ones
// Notes:   One stored word is enough for the bench traffic
`timescale 1ns/1ps
module mpp_mem_model
(
    input  wire logic        i_clock,
    input  wire logic        i_ale,
    input  wire logic        i_ale_active_low,
    input  wire logic [15:0] i_ad,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    output logic [15:0]      o_data,
    output logic [15:0]      o_oe,
    output logic [15:0]      o_latched
);
    logic [15:0] mem;
    // ==========
    // Latch and store
    // Capture address while strobe active, hold otherwise
    always_ff @(posedge i_clock)
    begin
        if (i_ale != i_ale_active_low)
        begin
            o_latched <= i_ad;
        end
        if (!i_wr_n)
        begin
            mem <= i_ad;
        end
    end
    // Drive stored word only while read strobe low
    assign o_oe   = i_rd_n ? 16'h0000 : 16'hffff;
    assign o_data = mem;
endmodule : mpp_mem_model

// ===== sim/muxed_parallel_port_and_flag_pins_tb.sv
// Purpose: Self-checking bench for the muxed port and signal pins
// Assumes: Inputs driven on falling edge, outputs counted on rising edge
// Notes:   Lines and signal pins resolved here from all enables
`timescale 1ns/1ps
module muxed_parallel_port_and_flag_pins_tb import mpp_pkg::*;;
    logic i_clock = 1'b0, i_rst = 1'b1, port_en = 1'b1, ale_low = 1'b0, boot = 1'b0, rv = 1'b0, tmr = 1'b0;
    logic [CTL_W-1:0] ctl = '0;
    mpp_req_t req = '0;
    mpp_gsp_cfg_t gc = '0;
    logic [3:0] gx = 4'h0, gw, o_gsp, o_gsp_oe, o_gsp_cond;
    logic [15:0] pf_out = 16'h0000, pf_oe = 16'h0000, ad_w, o_ad, o_ad_oe, pu, pf_in, ch0_in, m_data, m_oe, lat, rdd, r;
    logic rdy, rd_valid, rd_n, wr_n, ale;
    logic [2:0] irq;
    logic [7:0] ale_cnt = 8'h00, rd_cnt = 8'h00, wr_cnt = 8'h00;
    logic cnt_clr = 1'b0;
    int num_errors = 0, total_checks = 0;
    // ==========
    // Clock, wires and partner
    always #2.5 i_clock = ~i_clock;
    assign ad_w = (o_ad & o_ad_oe) | (m_data & m_oe & ~o_ad_oe) | ~(o_ad_oe | m_oe);
    assign gw   = (o_gsp & o_gsp_oe) | (gx & ~o_gsp_oe);
    mpp_port u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_sys_control(ctl), .i_port_en(port_en),
        .i_ale_active_low(ale_low), .i_spi_boot(boot), .i_req_valid(rv), .i_req(req), .o_req_ready(rdy),
        .o_rd_valid(rd_valid), .o_rd_data(rdd), .i_ad(ad_w), .o_ad(o_ad), .o_ad_oe(o_ad_oe),
        .o_ad_pullup_en(pu), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ale(ale), .i_pflag_out(pf_out),
        .i_pflag_oe(pf_oe), .o_pflag_in(pf_in), .o_in_port_ch0_data(ch0_in), .i_gsp_cfg(gc),
        .i_timer_expired(tmr), .i_gsp(gw), .o_gsp(o_gsp), .o_gsp_oe(o_gsp_oe), .o_gsp_cond(o_gsp_cond),
        .o_irq(irq));
    mpp_mem_model u_mem (.i_clock(i_clock), .i_ale(ale), .i_ale_active_low(ale_low), .i_ad(ad_w),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .o_data(m_data), .o_oe(m_oe), .o_latched(lat));
    // Strobe activity counters
    always @(posedge i_clock)
    begin
        ale_cnt <= cnt_clr ? 8'h00 : ale_cnt + 8'(ale !== ale_low);
        rd_cnt  <= cnt_clr ? 8'h00 : rd_cnt + 8'(rd_n === 1'b0);
        wr_cnt  <= cnt_clr ? 8'h00 : wr_cnt + 8'(wr_n === 1'b0);
    end
    // ==========
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task access(input logic wr, input logic wide, input logic [23:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge i_clock);
        cnt_clr = 1'b1;
        rv = 1'b1;
        req = '{wr, wide, a, d};
        @(posedge i_clock);
        while (rdy !== 1'b1 && n < 50)
        begin
            @(posedge i_clock);
            n++;
        end
        if (n == 50)
            num_errors++;
        @(negedge i_clock);
        rv = 1'b0;
        cnt_clr = 1'b0;
        r = 16'h0000;
        repeat (12)
        begin
            @(negedge i_clock);
            if (rd_valid === 1'b1) r = rdd;
        end
    endtask : access
    task finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // Watchdog
    initial
    begin
        #50000;
        num_errors++;
        finish_test();
    end
    // ==========
    // Tests
    initial
    begin
        repeat (3) @(negedge i_clock);
        check({rd_n, wr_n, ale}, 3'b110);
        check({o_ad_oe, pu}, 32'h0000ffff);
        i_rst = 1'b0;
        $display("test reset done");
        access(1'b1, 1'b1, 24'h001234, 16'hc0de);
        check({ale_cnt, wr_cnt, rd_cnt}, {8'd1, 8'(STROBE_CYC), 8'd0});
        check(lat, 16'h1234);
        access(1'b0, 1'b1, 24'h001234, 16'h0000);
        check({ale_cnt, rd_cnt, wr_cnt}, {8'd0, 8'(STROBE_CYC), 8'd0});
        check(r, 16'hc0de);
        access(1'b1, 1'b0, 24'hab1203, 16'h0077);
        check({ale_cnt, lat}, {8'd1, 16'hab12});
        access(1'b0, 1'b0, 24'hab12ff, 16'h0000);
        check({ale_cnt, r}, {8'd0, 16'h0077});
        $display("test port done");
        ale_low = 1'b1;
        repeat (2) @(negedge i_clock);
        check(ale, 1'b1);
        access(1'b1, 1'b1, 24'h005a5a, 16'h1111);
        check({ale_cnt, lat}, {8'd1, 16'h5a5a});
        ale_low = 1'b0;
        port_en = 1'b0;
        ctl[CTL_PFLAG_BIT] = 1'b1;
        pf_out = 16'ha5c3;
        pf_oe = 16'h00ff;
        rv = 1'b1;
        repeat (3) @(negedge i_clock);
        cnt_clr = 1'b1;
        @(negedge i_clock);
        cnt_clr = 1'b0;
        repeat (7) @(negedge i_clock);
        check({rdy, ale_cnt, rd_cnt, wr_cnt}, 0);
        check({pf_in, ch0_in}, 32'hffc3ffc3);
        rv = 1'b0;
        $display("test flag done");
        gc = '{4'b0110, 4'b0100, 4'b0000, 4'b0000};
        gx = 4'b1001;
        repeat (3) @(negedge i_clock);
        check({o_gsp_oe, gw, o_gsp_cond}, 12'h6dd);
        gc.spi_sel_en = 4'b1000;
        gc.spi_sel = 4'b1000;
        repeat (3) @(negedge i_clock);
        check({o_gsp_oe[3], o_gsp[3]}, 2'b11);
        gc = '0;
        ctl[18:16] = 3'b111;
        gx = 4'b0101;
        repeat (3) @(negedge i_clock);
        check(irq, 3'b101);
        ctl[18:16] = 3'b010;
        gx = 4'b0111;
        repeat (3) @(negedge i_clock);
        check(irq, 3'b010);
        ctl[CTL_TMR_EXP_BIT] = 1'b1;
        tmr = 1'b1;
        repeat (3) @(negedge i_clock);
        check({o_gsp_oe[3], o_gsp[3]}, 2'b11);
        tmr = 1'b0;
        boot = 1'b1;
        ctl[16] = 1'b1;
        repeat (3) @(negedge i_clock);
        check({o_gsp[3], o_gsp_oe[0], gw[0]}, 3'b010);
        $display("test signal pins done");
        finish_test();
    end
endmodule : muxed_parallel_port_and_flag_pins_tb
